// ===== logic/fsr_nv_cell.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_nv_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter int         ERASE_CYC = 1,
  parameter int         PROG_CYC  = 1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // update request
  input  wire logic       start,
  input  wire logic [7:0] value,
  // image and progress
  output var  logic [7:0] image,
  output var  logic       busy,
  output var  logic       done
);

  fsr_pkg::fsr_nv_state_t state_reg, state_next;  // sequence state
  logic [15:0] cnt_reg, cnt_next;                  // phase countdown
  logic [7:0]  pend_reg, pend_next;                // value to program
  logic [7:0]  image_next;
  logic        done_next;

  // erase then program, image shows erased byte between phases
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    image_next = image;
    done_next  = 1'b0;
    case (state_reg)
      fsr_pkg::NV_IDLE: begin
        // requests while busy are not seen by this cell
        if (start) begin
          state_next = fsr_pkg::NV_ERASE;
          cnt_next   = 16'(ERASE_CYC - 1);
          pend_next  = value;
        end
      end
      fsr_pkg::NV_ERASE: begin
        if (cnt_reg == 16'h0000) begin
          image_next = fsr_pkg::ERASED_BYTE;
          state_next = fsr_pkg::NV_PROG;
          cnt_next   = 16'(PROG_CYC - 1);
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      fsr_pkg::NV_PROG: begin
        if (cnt_reg == 16'h0000) begin
          image_next = pend_reg;
          done_next  = 1'b1;
          state_next = fsr_pkg::NV_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = fsr_pkg::NV_IDLE;
    endcase
  end

  // image resets to its factory value only on power-on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= fsr_pkg::NV_IDLE;
      cnt_reg   <= 16'h0000;
      pend_reg  <= 8'h00;
      image     <= RESET_VAL;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      image     <= image_next;
      busy      <= (state_next != fsr_pkg::NV_IDLE);
      done      <= done_next;
    end
  end

endmodule : fsr_nv_cell
`default_nettype wire

// ===== logic/fsr_pkg.sv
`default_nettype none
package fsr_pkg;

  // command opcodes seen on the command port
  localparam logic [7:0] OP_WREN       = 8'h06;  // set write enable latch
  localparam logic [7:0] OP_WRDI       = 8'h04;  // clear write enable latch
  localparam logic [7:0] OP_CLSR       = 8'h30;  // clear error status
  localparam logic [7:0] OP_CLSR_ALT   = 8'h82;  // clear error status, alias
  localparam logic [7:0] OP_RD_REG     = 8'h65;  // register_read_command
  localparam logic [7:0] OP_WR_REG     = 8'h71;  // register_write_command
  localparam logic [7:0] OP_PROGRAM    = 8'h02;  // page program
  localparam logic [7:0] OP_SECT_ERASE = 8'hD8;  // sector erase
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;  // whole_chip_erase
  localparam logic [7:0] OP_SOFT_RESET = 8'hF0;  // software reset

  // register addresses for read and write commands
  localparam logic [31:0] ADDR_SR1_NV = 32'h0000_0000;  // status one, nv
  localparam logic [31:0] ADDR_CR1_NV = 32'h0000_0002;  // config one, nv
  localparam logic [31:0] ADDR_SR1_V  = 32'h0080_0000;  // status one, vol
  localparam logic [31:0] ADDR_CR1_V  = 32'h0080_0002;  // config one, vol

  // field positions in status and config registers
  localparam int BIT_WRITE_LOCK = 7;  // persistent_write_lock
  localparam int BIT_PROG_ERR   = 6;  // program error
  localparam int BIT_ERASE_ERR  = 5;  // erase error
  localparam int BIT_BP_HI      = 4;  // block protect msb
  localparam int BIT_BP_LO      = 2;  // block protect lsb
  localparam int BIT_WEL        = 1;  // write_enable_latch
  localparam int BIT_BUSY       = 0;  // operation_busy
  localparam int BIT_BP_VOL_SEL = 3;  // protect_volatility_select

  // factory values of the non-volatile images
  localparam logic [7:0] SR1_NV_FACTORY = 8'h00;
  localparam logic [7:0] CR1_NV_FACTORY = 8'h00;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;  // image after erase
  localparam logic [2:0] BP_ALL_SET     = 3'h7;   // frozen nv protect
  localparam logic [2:0] BP_NONE        = 3'h0;   // nothing protected

  // non-volatile cell timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NV_ERASE_NS   = 2000;  // register erase time
  localparam int NV_PROG_NS    = 500;   // register program time
  localparam int NV_ERASE_CYC  = (NV_ERASE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int NV_PROG_CYC   = (NV_PROG_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // command as delivered by the serial front end
  typedef struct packed {
    logic [7:0]  opcode;  // instruction byte
    logic [31:0] addr;    // register or array address
    logic [7:0]  data;    // write data byte
  } fsr_cmd_t;

  // status one volatile layout
  typedef struct packed {
    logic       write_lock;  // write_lock_copy
    logic       prog_err;    // program error
    logic       erase_err;   // erase error
    logic [2:0] protect;     // volatile block protect
    logic       write_enable_latch;         // write_enable_latch
    logic       busy;        // operation_busy
  } fsr_sr1_t;

  // states of the non-volatile update sequence
  typedef enum logic [1:0] {
    NV_IDLE,
    NV_ERASE,
    NV_PROG
  } fsr_nv_state_t;

endpackage : fsr_pkg
`default_nettype wire

// ===== logic/fsr_status_bank.sv
// Contract
// - reads of shadowed register return volatile copy
// - any reset reloads volatile from non-volatile
// - nv write: erase, program, then refresh volatile
// - otp programming updates only matching volatile bits
// - volatile writes leave non-volatile image alone
// - reset defaults volatile; factory defaults non-volatile
// - lock bit plus low pin blocks status/config writes
// - pin high or lock clear: writes accepted
// - pin never blocks other registers
// - volatile lock bit mirrors non-volatile lock bit
// - nv bits 6,5 give error defaults, read-only
// - nv bits 1,0 give latch/busy defaults, read-only
// - nv protect mode: write nv, copy to volatile
// - volatile protect mode: write volatile only
// - entering volatile mode sets nv protect 111b
// - protected area refuses program and erase
// - chip erase only with protect bits clear
// - 65h reads, 71h writes registers
// - writes, programs, erases need write latch set
// - busy reads 1 during operation, while an error flag or the busy default is set, else 0
`timescale 1ns/10ps
`default_nettype none
module fsr_status_bank #(
  parameter int ADDR_W    = 27,
  parameter int ERASE_CYC = fsr_pkg::NV_ERASE_CYC,
  parameter int PROG_CYC  = fsr_pkg::NV_PROG_CYC
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // device pins
  input  wire logic             wp_pin_b,
  input  wire logic             hw_reset_pin_b,
  // decoded commands from the serial front end
  input  wire logic             cmd_valid,
  input  wire fsr_pkg::fsr_cmd_t cmd,
  // register read answer
  output var  logic             rd_valid,
  output var  logic [7:0]       rd_data,
  // array engine handshake
  output var  logic             array_go,
  output var  logic [7:0]       array_op,
  output var  logic [31:0]      array_addr,
  input  wire logic             array_done,
  input  wire logic             array_fail,
  // status view
  output var  logic [7:0]       status_byte,
  output var  logic [2:0]       protect_active
);

  // synchronised pins
  logic [1:0] pins_sync;               // {hw reset, write protect}
  logic       wp_sync_b;               // write-protect pin, low locks
  logic       hwrst_sync_b;            // hardware reset, low active

  // non-volatile images and their sequencers
  logic [7:0] sr_nv;                   // status_one_nonvolatile
  logic [7:0] cr_nv;                   // config_one_nonvolatile
  logic       sr_busy, cr_busy;        // update sequences running
  logic       sr_done, cr_done;        // update finished pulses
  logic       sr_start, cr_start;      // update requests
  logic [7:0] sr_value, cr_value;      // values to program

  // volatile state
  logic [2:0] bpv_reg, bpv_next;       // volatile protect bits
  logic       perr_reg, perr_next;     // program error
  logic       eerr_reg, eerr_next;     // erase error
  logic       wel_reg, wel_next;       // write_enable_latch
  logic       wipd_reg, wipd_next;     // busy default from nv bit 0
  logic [7:0] config_one_volatile_reg, config_one_volatile_next;     // config_one_volatile
  logic       arr_reg, arr_next;       // array operation running

  // output registers
  logic        rd_valid_next;
  logic [7:0]  rd_data_next;
  logic        go_next;
  logic [7:0]  op_next;
  logic [31:0] addr_next;

  // derived views
  logic             busy;              // operation_busy
  logic             bp_vol_sel;        // protect_volatility_select
  logic [2:0]       bp_active;         // protect bits in force
  logic             wr_lock;           // status/config writes blocked
  logic             reload;            // hardware or software reset
  fsr_pkg::fsr_sr1_t status_one_volatile;             // status_one_volatile

  // pins cross into the clock domain
  fsr_sync2 #(
    .W        (2)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({hw_reset_pin_b, wp_pin_b}),
    .sync_out (pins_sync)
  );

  assign wp_sync_b    = pins_sync[0];
  assign hwrst_sync_b = pins_sync[1];

  // status one non-volatile image
  fsr_nv_cell #(
    .RESET_VAL (fsr_pkg::SR1_NV_FACTORY),
    .ERASE_CYC (ERASE_CYC),
    .PROG_CYC  (PROG_CYC)
  ) u_sr_nv (
    .clk       (clk),
    .rst_b     (rst_b),
    .start     (sr_start),
    .value     (sr_value),
    .image     (sr_nv),
    .busy      (sr_busy),
    .done      (sr_done)
  );

  // config one non-volatile image
  fsr_nv_cell #(
    .RESET_VAL (fsr_pkg::CR1_NV_FACTORY),
    .ERASE_CYC (ERASE_CYC),
    .PROG_CYC  (PROG_CYC)
  ) u_cr_nv (
    .clk       (clk),
    .rst_b     (rst_b),
    .start     (cr_start),
    .value     (cr_value),
    .image     (cr_nv),
    .busy      (cr_busy),
    .done      (cr_done)
  );

  // true when addr falls in the top area that bp selects
  function automatic logic in_protected(input logic [2:0]  bp,
                                        input logic [31:0] addr);
    logic [31:0] top;
    int          span;
    top  = 32'h0000_0000;
    span = 7 - int'(bp);
    if (bp == fsr_pkg::BP_NONE) begin
      in_protected = 1'b0;
    end else if (bp == fsr_pkg::BP_ALL_SET) begin
      in_protected = 1'b1;
    end else begin
      top          = addr >> (ADDR_W - span);
      in_protected = (top == ((32'h0000_0001 << span) - 32'h0000_0001));
    end
  endfunction : in_protected

  // derived status
  always_comb begin
    bp_vol_sel = cr_nv[fsr_pkg::BIT_BP_VOL_SEL];
    bp_active  = bp_vol_sel ? bpv_reg
               : sr_nv[fsr_pkg::BIT_BP_HI:fsr_pkg::BIT_BP_LO];
    busy = sr_busy | cr_busy | arr_reg | perr_reg | eerr_reg
         | wipd_reg | sr_done | cr_done;
    wr_lock = sr_nv[fsr_pkg::BIT_WRITE_LOCK] & ~wp_sync_b;
    reload  = ~hwrst_sync_b
            | (cmd_valid & (cmd.opcode == fsr_pkg::OP_SOFT_RESET));
    status_one_volatile.write_lock = sr_nv[fsr_pkg::BIT_WRITE_LOCK];
    status_one_volatile.prog_err   = perr_reg;
    status_one_volatile.erase_err  = eerr_reg;
    status_one_volatile.protect    = bpv_reg;
    status_one_volatile.write_enable_latch        = wel_reg;
    status_one_volatile.busy       = busy;
  end

  // command decode, array completion, reset reload
  always_comb begin
    bpv_next      = bpv_reg;
    perr_next     = perr_reg;
    eerr_next     = eerr_reg;
    wel_next      = wel_reg;
    wipd_next     = wipd_reg;
    config_one_volatile_next     = config_one_volatile_reg;
    arr_next      = arr_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data;
    go_next       = 1'b0;
    op_next       = array_op;
    addr_next     = array_addr;
    sr_start      = 1'b0;
    cr_start      = 1'b0;
    sr_value      = sr_nv;
    cr_value      = cr_nv;
    // volatile refresh once a non-volatile update completes
    if (sr_done) begin
      wel_next = 1'b0;
      if (!bp_vol_sel) begin
        bpv_next = sr_nv[fsr_pkg::BIT_BP_HI:fsr_pkg::BIT_BP_LO];
      end
    end
    if (cr_done) begin
      config_one_volatile_next = cr_nv;
      wel_next  = 1'b0;
    end
    if (cmd_valid) begin
      case (cmd.opcode)
        fsr_pkg::OP_WREN: begin
          if (!busy) wel_next = 1'b1;
        end
        fsr_pkg::OP_WRDI: begin
          if (!busy) wel_next = 1'b0;
        end
        fsr_pkg::OP_CLSR, fsr_pkg::OP_CLSR_ALT: begin
          perr_next = 1'b0;
          eerr_next = 1'b0;
          wipd_next = 1'b0;
        end
        fsr_pkg::OP_RD_REG: begin
          rd_valid_next = 1'b1;
          case (cmd.addr)
            fsr_pkg::ADDR_SR1_NV: rd_data_next = sr_nv;
            fsr_pkg::ADDR_CR1_NV: rd_data_next = cr_nv;
            fsr_pkg::ADDR_SR1_V:  rd_data_next = status_one_volatile;
            fsr_pkg::ADDR_CR1_V:  rd_data_next = config_one_volatile_reg;
            default:              rd_data_next = 8'h00;
          endcase
        end
        fsr_pkg::OP_WR_REG: begin
          // ignored without latch or while any operation runs
          if (wel_reg && !busy) begin
            case (cmd.addr)
              fsr_pkg::ADDR_SR1_NV: begin
                if (!wr_lock) begin
                  sr_start = 1'b1;
                  sr_value = {cmd.data[fsr_pkg::BIT_WRITE_LOCK],
                              sr_nv[fsr_pkg::BIT_PROG_ERR:
                                    fsr_pkg::BIT_ERASE_ERR],
                              bp_vol_sel
                                ? sr_nv[fsr_pkg::BIT_BP_HI:fsr_pkg::BIT_BP_LO]
                                : cmd.data[fsr_pkg::BIT_BP_HI:
                                           fsr_pkg::BIT_BP_LO],
                              sr_nv[fsr_pkg::BIT_WEL:
                                    fsr_pkg::BIT_BUSY]};
                end
              end
              fsr_pkg::ADDR_SR1_V: begin
                if (!wr_lock) begin
                  if (bp_vol_sel) begin
                    bpv_next = cmd.data[fsr_pkg::BIT_BP_HI:
                                        fsr_pkg::BIT_BP_LO];
                  end
                  wel_next = 1'b0;
                end
              end
              fsr_pkg::ADDR_CR1_NV: begin
                if (!wr_lock) begin
                  cr_start = 1'b1;
                  cr_value = cmd.data;
                  // otp bit can only be set, never cleared
                  cr_value[fsr_pkg::BIT_BP_VOL_SEL] = bp_vol_sel
                    | cmd.data[fsr_pkg::BIT_BP_VOL_SEL];
                  if (!bp_vol_sel && cmd.data[fsr_pkg::BIT_BP_VOL_SEL]) begin
                    sr_start = 1'b1;
                    sr_value = sr_nv;
                    sr_value[fsr_pkg::BIT_BP_HI:fsr_pkg::BIT_BP_LO] =
                      fsr_pkg::BP_ALL_SET;
                  end
                end
              end
              fsr_pkg::ADDR_CR1_V: begin
                if (!wr_lock) begin
                  config_one_volatile_next = cmd.data;
                  config_one_volatile_next[fsr_pkg::BIT_BP_VOL_SEL] =
                    config_one_volatile_reg[fsr_pkg::BIT_BP_VOL_SEL];
                  wel_next  = 1'b0;
                end
              end
              // other registers never see the pin lock
              default: wel_next = wel_reg;
            endcase
          end
        end
        fsr_pkg::OP_PROGRAM, fsr_pkg::OP_SECT_ERASE: begin
          if (wel_reg && !busy) begin
            if (in_protected(bp_active, cmd.addr)) begin
              if (cmd.opcode == fsr_pkg::OP_PROGRAM) perr_next = 1'b1;
              else eerr_next = 1'b1;
            end else begin
              go_next   = 1'b1;
              op_next   = cmd.opcode;
              addr_next = cmd.addr;
              arr_next  = 1'b1;
            end
          end
        end
        fsr_pkg::OP_CHIP_ERASE: begin
          // refused silently while any protect bit is set
          if (wel_reg && !busy && bp_active == fsr_pkg::BP_NONE) begin
            go_next   = 1'b1;
            op_next   = cmd.opcode;
            addr_next = 32'h0000_0000;
            arr_next  = 1'b1;
          end
        end
        default: arr_next = arr_reg;
      endcase
    end
    // array completion; error set wins over a same-cycle clear
    if (arr_reg && array_done) begin
      arr_next = 1'b0;
      if (array_fail) begin
        if (array_op == fsr_pkg::OP_PROGRAM) perr_next = 1'b1;
        else eerr_next = 1'b1;
      end else begin
        wel_next = 1'b0;
      end
    end
    // hardware or software reset reloads volatile from nv
    if (reload) begin
      bpv_next  = sr_nv[fsr_pkg::BIT_BP_HI:fsr_pkg::BIT_BP_LO];
      perr_next = sr_nv[fsr_pkg::BIT_PROG_ERR];
      eerr_next = sr_nv[fsr_pkg::BIT_ERASE_ERR];
      wel_next  = sr_nv[fsr_pkg::BIT_WEL];
      wipd_next = sr_nv[fsr_pkg::BIT_BUSY];
      config_one_volatile_next = cr_nv;
    end
  end

  // register stage; power-on values equal factory nv copies
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bpv_reg        <= fsr_pkg::SR1_NV_FACTORY[fsr_pkg::BIT_BP_HI:
                                                fsr_pkg::BIT_BP_LO];
      perr_reg       <= fsr_pkg::SR1_NV_FACTORY[fsr_pkg::BIT_PROG_ERR];
      eerr_reg       <= fsr_pkg::SR1_NV_FACTORY[fsr_pkg::BIT_ERASE_ERR];
      wel_reg        <= fsr_pkg::SR1_NV_FACTORY[fsr_pkg::BIT_WEL];
      wipd_reg       <= fsr_pkg::SR1_NV_FACTORY[fsr_pkg::BIT_BUSY];
      config_one_volatile_reg       <= fsr_pkg::CR1_NV_FACTORY;
      arr_reg        <= 1'b0;
      rd_valid       <= 1'b0;
      rd_data        <= 8'h00;
      array_go       <= 1'b0;
      array_op       <= 8'h00;
      array_addr     <= 32'h0000_0000;
      status_byte    <= 8'h00;
      protect_active <= 3'h0;
    end else begin
      bpv_reg        <= bpv_next;
      perr_reg       <= perr_next;
      eerr_reg       <= eerr_next;
      wel_reg        <= wel_next;
      wipd_reg       <= wipd_next;
      config_one_volatile_reg       <= config_one_volatile_next;
      arr_reg        <= arr_next;
      rd_valid       <= rd_valid_next;
      rd_data        <= rd_data_next;
      array_go       <= go_next;
      array_op       <= op_next;
      array_addr     <= addr_next;
      status_byte    <= status_one_volatile;
      protect_active <= bp_active;
    end
  end

endmodule : fsr_status_bank
`default_nettype wire

// ===== logic/fsr_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;  // first stage, read only by second stage

  // two flops, idle high since pins are active-low levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : fsr_sync2
`default_nettype wire

// ===== tb/flash_status_register_shadowing_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_status_register_shadowing_test;
  localparam logic [31:0] SV = 32'h0080_0000; // status one volatile
  logic clk, rst_b, wp_pin_b, hw_reset_pin_b, cmd_valid, rd_valid;
  logic array_go, array_done, array_fail;
  logic [7:0] rd_data, array_op, status_byte, gos, g, d, nv, v;
  logic [31:0] array_addr;
  logic [2:0] protect_active;
  fsr_pkg::fsr_cmd_t cmd;
  int errors, compares;
  fsr_status_bank #(.ERASE_CYC(3), .PROG_CYC(2)) fsr_status_bank_inst (
    .clk, .rst_b, .wp_pin_b, .hw_reset_pin_b, .cmd_valid, .cmd,
    .rd_valid, .rd_data, .array_go, .array_op, .array_addr,
    .array_done, .array_fail, .status_byte, .protect_active);
  fsr_host_model fsr_host_model_inst (.clk, .rd_valid, .rd_data,
    .cmd_valid, .cmd);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // array engine stand-in: finishes one cycle after each start
  always @(negedge clk) array_done = array_go;
  always @(posedge clk)
    if (!rst_b) gos <= 8'h00;
    else if (array_go) gos <= gos + 8'h01;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdv(input logic [31:0] a, output logic [7:0] val);
    logic ok;
    fsr_host_model_inst.read(a, ok, val);
    check({7'h00, ok}, 8'h01);
  endtask : rdv
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] val;
    rdv(a, val);
    check(val, exp);
  endtask : rd
  // poll busy under a bounded count
  task automatic wait_idle();
    logic [7:0] val;
    for (int i = 0; i < 100; i++) begin
      rdv(SV, val);
      if (val[0] === 1'b0) return;
    end
    check(val, 8'h00);
  endtask : wait_idle
  // status one nv after a write: fixed bits kept, protect kept in vol mode
  function automatic logic [7:0] nv_exp(input logic [7:0] old, dat,
                                        input logic vmode);
    nv_exp = vmode ? ((dat & 8'h80) | (old & 8'h7F))
                   : ((dat & 8'h9C) | (old & 8'h63));
  endfunction : nv_exp
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst_b = 1'b0;
    wp_pin_b = 1'b1;
    hw_reset_pin_b = 1'b1;
    array_done = 1'b0;
    array_fail = 1'b0;
    void'($urandom(87));
    repeat (4) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    @(negedge clk);
    rd(32'h0, 8'h00);
    rd(32'h2, 8'h00);
    rd(SV, 8'h00);
    $display("defaults test done");
    d = {3'h0, 3'($urandom_range(6, 1)), 2'h0};
    fsr_host_model_inst.write(32'h0, d | 8'h63);
    wait_idle();
    nv = nv_exp(8'h00, d | 8'h63, 1'b0);
    rd(32'h0, nv);
    rd(SV, nv);
    g = gos;
    fsr_host_model_inst.send(8'h06, 32'h0, 8'h00);
    fsr_host_model_inst.send(8'h02, 32'h07FF_FF00, 8'h00);
    repeat (4) @(negedge clk);
    check(gos, g);
    rdv(SV, v);
    check(v & 8'h41, 8'h41);
    fsr_host_model_inst.send(8'h30, 32'h0, 8'h00);
    fsr_host_model_inst.send(8'hD8, 32'h07FF_0000, 8'h00);
    rdv(SV, v);
    check(v & 8'h21, 8'h21);
    fsr_host_model_inst.send(8'h82, 32'h0, 8'h00);
    fsr_host_model_inst.send(8'h04, 32'h0, 8'h00);
    rd(SV, nv);
    $display("protect test done");
    fsr_host_model_inst.write(32'h0, nv | 8'h80);
    wait_idle();
    nv = nv_exp(nv, nv | 8'h80, 1'b0);
    rd(SV, nv);
    check(status_byte, nv);
    wp_pin_b = 1'b0;
    repeat (4) @(negedge clk);
    fsr_host_model_inst.write(32'h2, 8'h08);
    repeat (8) @(negedge clk);
    rd(32'h2, 8'h00);
    wp_pin_b = 1'b1;
    repeat (4) @(negedge clk);
    fsr_host_model_inst.write(32'h2, 8'h08);
    wait_idle();
    rd(32'h2, 8'h08);
    nv = nv | 8'h1C;
    rd(32'h0, nv);
    $display("lock test done");
    fsr_host_model_inst.write(SV, 8'h00);
    repeat (4) @(negedge clk);
    rdv(SV, v);
    check(v & 8'hFD, 8'h80);
    rd(32'h0, nv);
    g = gos;
    fsr_host_model_inst.send(8'h06, 32'h0, 8'h00);
    fsr_host_model_inst.send(8'h60, 32'h0, 8'h00);
    wait_idle();
    check(gos, g + 8'h01);
    hw_reset_pin_b = 1'b0;
    repeat (4) @(negedge clk);
    hw_reset_pin_b = 1'b1;
    repeat (4) @(negedge clk);
    rd(SV, nv);
    check({5'h00, protect_active}, 8'h07);
    fsr_host_model_inst.write(SV, 8'h00);
    fsr_host_model_inst.send(8'hF0, 32'h0, 8'h00);
    repeat (2) @(negedge clk);
    rd(SV, nv);
    g = gos;
    fsr_host_model_inst.send(8'h06, 32'h0, 8'h00);
    fsr_host_model_inst.send(8'h60, 32'h0, 8'h00);
    repeat (6) @(negedge clk);
    check(gos, g);
    $display("volatile and reset test done");
    wrap_up();
  end
endmodule : flash_status_register_shadowing_test
`default_nettype wire

// ===== tb/fsr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_host_model (
  // clock
  input  wire logic              clk,
  // read answer
  input  wire logic              rd_valid,
  input  wire logic [7:0]        rd_data,
  // command strobe and word
  output var  logic              cmd_valid,
  output var  fsr_pkg::fsr_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // one command, held over one rising edge, scrambled once released
  task automatic send(input logic [7:0] op, input logic [31:0] a,
                      input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd       = {op, a, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd       = {~op, ~a, ~d};
  endtask : send
  // read: answer stands one cycle after the taking edge
  task automatic read(input logic [31:0] a, output logic ok,
                      output logic [7:0] v);
    send(8'h65, a, 8'h00);
    ok = rd_valid;
    v  = rd_data;
  endtask : read
  // write, always preceded by setting the write latch
  task automatic write(input logic [31:0] a, input logic [7:0] d);
    send(8'h06, 32'h0, 8'h00);
    send(8'h71, a, d);
  endtask : write
endmodule : fsr_host_model
`default_nettype wire

// ===== tb/fsr_status_bank_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fsr_status_bank_asserts #(
  parameter int ADDR_W    = 27,
  parameter int ERASE_CYC = 1,
  parameter int PROG_CYC  = 1
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // command side
  input wire logic              cmd_valid,
  input wire fsr_pkg::fsr_cmd_t cmd,
  // answers
  input wire logic              rd_valid,
  input wire logic [7:0]        rd_data,
  input wire logic              array_go,
  input wire logic [7:0]        array_op,
  input wire logic [31:0]       array_addr,
  input wire logic [2:0]        protect_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (
    cmd_valid && cmd.opcode == 8'h65 |=> rd_valid)
    else $error("register read got no answer");
  a_read_cause: assert property (
    rd_valid |-> $past(cmd_valid) && $past(cmd.opcode) == 8'h65)
    else $error("read answer without read command");
  a_read_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved without answer");
  a_go_cause: assert property (
    array_go |-> $past(cmd_valid) && $past(cmd.opcode) == array_op)
    else $error("array start without matching command");
  a_op_hold: assert property (!array_go |-> $stable(array_op))
    else $error("array opcode moved without start");
  a_chip_clear: assert property (
    array_go && array_op == 8'h60 |-> protect_active == 3'h0)
    else $error("chip erase started while protected");
  a_chip_addr: assert property (
    array_go && array_op == 8'h60 |-> array_addr == 32'h0)
    else $error("chip erase address not zero");
  a_go_single: assert property (array_go |=> !array_go)
    else $error("array start longer than one cycle");
endmodule : fsr_status_bank_asserts
bind fsr_status_bank fsr_status_bank_asserts #(
  .ADDR_W(ADDR_W), .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)
) chk_inst (.clk, .rst_b, .cmd_valid, .cmd, .rd_valid, .rd_data,
  .array_go, .array_op, .array_addr, .protect_active);
`default_nettype wire
